// ==== src/fieldbus_object_mapper_defs.svh ====
/*
  Constants of the fieldbus object mapper: object index offset, register
  numbers, codes, status bit positions, abort codes and frame sizes.
  Assumes it is included by bare name from the design files.
*/
// Functional notes
// - Slots 1-4 carry status, voltage, current and power; slots 5-8 are zero.
// - Status in four bytes, actuals in two each, MSB first, in slot order.
// - Status bit 6 means master, bit 7 output on, bit 10 constant current.
// - Status bit 12 flags sink mode, so current and power may be inverted.
// - Current and power are unsigned; only the sink bit carries the sign.
// - Percent codes are linear: 0x0000 is zero, 0xCCCC full nominal value.
// - All 52429 set codes are taken but resolve to 26215 output steps.
// - An object index minus 0x2001 gives the internal register number.
// - Register 121 reads nominal voltage as a 32-bit single-precision float.
// - 0xFF00 to register 402 requests remote control, 0x0000 releases it.
// - Set-value writes are accepted only while remote control is granted.
// - Reads are answered at any time, remote control or not.
// - A write out of range under remote control is refused with the range-exceeded abort code.
// - A write the present state forbids gets the state abort code.
`ifndef FIELDBUS_OBJECT_MAPPER_DEFS_SVH
`define FIELDBUS_OBJECT_MAPPER_DEFS_SVH

// ==========================================================
// Object addressing
`define OBJ_INDEX_OFFSET      16'h2001
`define REG_NOMINAL_VOLTAGE   16'h0079
`define REG_REMOTE_REQUEST    16'h0192
`define REG_SET_VOLTAGE       16'h01F4
`define REG_SET_CURRENT       16'h01F5
`define REG_SET_POWER         16'h01F6
`define REG_STATUS_WORD       16'h01F9
`define REG_MEAS_VOLTAGE      16'h01FB
`define REG_MEAS_CURRENT      16'h01FC
`define REG_MEAS_POWER        16'h01FD

// ==========================================================
// Codes and status bits
`define REMOTE_ON_CODE        16'hFF00
`define REMOTE_OFF_CODE       16'h0000
`define PERCENT_ZERO          16'h0000
`define PERCENT_FULL          16'hCCCC
`define STAT_BIT_MASTER       6
`define STAT_BIT_OUTPUT_ON    7
`define STAT_BIT_CC           10
`define STAT_BIT_SINK         12
`define NOMINAL_VOLTAGE_INIT  32'h4348_0000

// ==========================================================
// Abort codes
`define ABORT_NONE            32'h0000_0000
`define ABORT_NO_OBJECT       32'h0602_0000
`define ABORT_READ_ONLY       32'h0601_0002
`define ABORT_RANGE           32'h0609_0030
`define ABORT_STATE           32'h0800_0022

// ==========================================================
// Cyclic frame
`define CYC_IMAGE_BITS        80
`define CYC_FRAME_LAST        5'd17
`define CYC_USED_BYTES        5'd10

`endif

// ==== src/fieldbus_object_mapper_pkg.sv ====
/*
  Types shared by the object mapper and its cyclic slot packer.
  Assumes nothing of its surroundings.
*/
package fieldbus_object_mapper_pkg;
  // ==========================================================
  // Packer sequencer states, one-hot
  typedef enum logic [1:0] {
    pk_idle = 2'b01,
    pk_send = 2'b10
  } pack_state_t;
endpackage

// ==== src/cyclic_slot_packer.sv ====
/*
  Serialises one captured cyclic image into the eight-slot byte frame.
  Assumes a one-cycle load pulse from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_object_mapper_defs.svh"

module cyclic_slot_packer (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        load,
  input  wire logic [`CYC_IMAGE_BITS-1:0]  image_in,
  output logic                             cyc_valid,
  output logic [7:0]                       cyc_data,
  output logic                             cyc_last
);
  import fieldbus_object_mapper_pkg::*;

  pack_state_t                 state;
  pack_state_t                 next_state;
  logic [`CYC_IMAGE_BITS-1:0]  image;
  logic [`CYC_IMAGE_BITS-1:0]  next_image;
  logic [4:0]                  count;
  logic [4:0]                  next_count;
  logic                        next_valid;
  logic [7:0]                  next_data;
  logic                        next_last;

  // ==========================================================
  // Sequencer: a load while a frame runs is ignored
  always_comb begin
    next_state = state;
    next_image = image;
    next_count = count;
    next_valid = 1'b0;
    next_data  = 8'h00;
    next_last  = 1'b0;
    case (state)
      pk_idle: begin
        if (load) begin
          next_image = image_in;
          next_count = 5'd0;
          next_state = pk_send;
        end
      end
      pk_send: begin
        next_valid = 1'b1;
        // Top byte first; zeros shift in, so slots 5-8 come out empty
        next_data  = image[`CYC_IMAGE_BITS-1 -: 8];
        next_image = {image[`CYC_IMAGE_BITS-9:0], 8'h00};
        next_last  = (count == `CYC_FRAME_LAST);
        next_count = count + 5'd1;
        if (count == `CYC_FRAME_LAST) begin
          next_state = pk_idle;
        end
      end
      default: next_state = pk_idle;
    endcase
  end

  // ==========================================================
  // State and output registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state     <= pk_idle;
      image     <= '0;
      count     <= 5'd0;
      cyc_valid <= 1'b0;
      cyc_data  <= 8'h00;
      cyc_last  <= 1'b0;
    end else begin
      state     <= next_state;
      image     <= next_image;
      count     <= next_count;
      cyc_valid <= next_valid;
      cyc_data  <= next_data;
      cyc_last  <= next_last;
    end
  end

endmodule
`default_nettype wire

// ==== src/fieldbus_object_mapper.sv ====
/*
  Fieldbus object layer: maps object indexes to registers, gates set
  values behind remote control and builds the cyclic slot image.
  Assumes requests and live values come from logic on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_object_mapper_defs.svh"

module fieldbus_object_mapper #(
  parameter logic [31:0] nominal_voltage_float = `NOMINAL_VOLTAGE_INIT
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         req_valid,
  input  wire logic         req_write,
  input  wire logic [15:0]  req_index,
  input  wire logic [31:0]  req_data,
  input  wire logic         remote_permit,
  input  wire logic         is_master,
  input  wire logic         output_on,
  input  wire logic         constant_current_regulation,
  input  wire logic         sink_mode,
  input  wire logic [31:0]  status_other,
  input  wire logic [15:0]  meas_voltage,
  input  wire logic [16:0]  meas_current,
  input  wire logic [16:0]  meas_power,
  input  wire logic         cyc_req,
  output logic              resp_valid,
  output logic              resp_ok,
  output logic [31:0]       resp_data,
  output logic [31:0]       resp_abort,
  output logic              remote_active,
  output logic [14:0]       set_voltage_eff,
  output logic [14:0]       set_current_eff,
  output logic [14:0]       set_power_eff,
  output logic              cyc_valid,
  output logic [7:0]        cyc_data,
  output logic              cyc_last
);
  import fieldbus_object_mapper_pkg::*;

  logic [15:0]  reg_num;
  logic [31:0]  status_word;
  logic [15:0]  current_mag;
  logic [15:0]  power_mag;
  logic [15:0]  set_voltage;
  logic [15:0]  set_current;
  logic [15:0]  set_power;
  logic [15:0]  next_set_voltage;
  logic [15:0]  next_set_current;
  logic [15:0]  next_set_power;
  logic         next_remote;
  logic         next_resp_valid;
  logic [31:0]  next_resp_data;
  logic [31:0]  next_resp_abort;
  logic [4:0]   cyc_idx;

  // ==========================================================
  // Two's complement reading to clamped unsigned magnitude
  function automatic logic [15:0] magnitude(input logic [16:0] v);
    logic [16:0] a;
    a = v[16] ? (~v + 17'h00001) : v;
    magnitude = a[16] ? 16'hFFFF : a[15:0];
  endfunction

  // State gate first, then range, so a locked unit never checks data
  function automatic logic [31:0] set_fault(input logic        rem,
                                            input logic [31:0] d);
    if (!rem) begin
      set_fault = `ABORT_STATE;
    end else if (d > {16'h0000, `PERCENT_FULL}) begin
      set_fault = `ABORT_RANGE;
    end else begin
      set_fault = `ABORT_NONE;
    end
  endfunction

  // ==========================================================
  // Live status word and unsigned actual values
  always_comb begin
    status_word = status_other;
    status_word[`STAT_BIT_MASTER]    = is_master;
    status_word[`STAT_BIT_OUTPUT_ON] = output_on;
    status_word[`STAT_BIT_CC]        = constant_current_regulation;
    status_word[`STAT_BIT_SINK]      = sink_mode;
    current_mag = magnitude(meas_current);
    power_mag   = magnitude(meas_power);
  end

  // ==========================================================
  // Object access: one request per cycle, answered the next cycle
  always_comb begin
    reg_num          = req_index - `OBJ_INDEX_OFFSET;
    next_set_voltage = set_voltage;
    next_set_current = set_current;
    next_set_power   = set_power;
    next_remote      = remote_active;
    next_resp_valid  = req_valid;
    next_resp_data   = 32'h0000_0000;
    next_resp_abort  = `ABORT_NONE;
    if (!req_valid) begin
      next_resp_valid = 1'b0;
    end else if (req_index < `OBJ_INDEX_OFFSET) begin
      next_resp_abort = `ABORT_NO_OBJECT;
    end else if (req_write) begin
      case (reg_num)
        `REG_REMOTE_REQUEST: begin
          if (req_data == {16'h0000, `REMOTE_ON_CODE}) begin
            // Grant may be denied by the unit's own control location
            if (remote_permit) begin
              next_remote = 1'b1;
            end else begin
              next_resp_abort = `ABORT_STATE;
            end
          end else if (req_data == {16'h0000, `REMOTE_OFF_CODE}) begin
            next_remote = 1'b0;
          end else begin
            next_resp_abort = `ABORT_RANGE;
          end
        end
        `REG_SET_VOLTAGE: begin
          next_resp_abort = set_fault(remote_active, req_data);
          if (next_resp_abort == `ABORT_NONE) begin
            next_set_voltage = req_data[15:0];
          end
        end
        `REG_SET_CURRENT: begin
          next_resp_abort = set_fault(remote_active, req_data);
          if (next_resp_abort == `ABORT_NONE) begin
            next_set_current = req_data[15:0];
          end
        end
        `REG_SET_POWER: begin
          next_resp_abort = set_fault(remote_active, req_data);
          if (next_resp_abort == `ABORT_NONE) begin
            next_set_power = req_data[15:0];
          end
        end
        `REG_NOMINAL_VOLTAGE, `REG_STATUS_WORD, `REG_MEAS_VOLTAGE,
        `REG_MEAS_CURRENT, `REG_MEAS_POWER: begin
          next_resp_abort = `ABORT_READ_ONLY;
        end
        default: next_resp_abort = `ABORT_NO_OBJECT;
      endcase
    end else begin
      // Reads are never gated by remote control
      case (reg_num)
        `REG_NOMINAL_VOLTAGE: next_resp_data = nominal_voltage_float;
        `REG_REMOTE_REQUEST:
          next_resp_data = remote_active ? {16'h0000, `REMOTE_ON_CODE}
                                         : {16'h0000, `REMOTE_OFF_CODE};
        `REG_SET_VOLTAGE:  next_resp_data = {16'h0000, set_voltage};
        `REG_SET_CURRENT:  next_resp_data = {16'h0000, set_current};
        `REG_SET_POWER:    next_resp_data = {16'h0000, set_power};
        `REG_STATUS_WORD:  next_resp_data = status_word;
        `REG_MEAS_VOLTAGE: next_resp_data = {16'h0000, meas_voltage};
        `REG_MEAS_CURRENT: next_resp_data = {16'h0000, current_mag};
        `REG_MEAS_POWER:   next_resp_data = {16'h0000, power_mag};
        default:           next_resp_abort = `ABORT_NO_OBJECT;
      endcase
    end
  end

  // ==========================================================
  // Registers; output stage drops the LSB, halving set resolution
  always_ff @(posedge core_clk) begin
    if (rst) begin
      remote_active   <= 1'b0;
      set_voltage     <= `PERCENT_ZERO;
      set_current     <= `PERCENT_ZERO;
      set_power       <= `PERCENT_ZERO;
      set_voltage_eff <= 15'h0000;
      set_current_eff <= 15'h0000;
      set_power_eff   <= 15'h0000;
      resp_valid      <= 1'b0;
      resp_ok         <= 1'b0;
      resp_data       <= 32'h0000_0000;
      resp_abort      <= `ABORT_NONE;
    end else begin
      remote_active   <= next_remote;
      set_voltage     <= next_set_voltage;
      set_current     <= next_set_current;
      set_power       <= next_set_power;
      set_voltage_eff <= next_set_voltage[15:1];
      set_current_eff <= next_set_current[15:1];
      set_power_eff   <= next_set_power[15:1];
      resp_valid      <= next_resp_valid;
      resp_ok         <= next_resp_valid && (next_resp_abort == `ABORT_NONE);
      resp_data       <= next_resp_data;
      resp_abort      <= next_resp_abort;
    end
  end

  // ==========================================================
  // Cyclic frame: image taken from live values at the request
  cyclic_slot_packer packer (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (cyc_req),
    .image_in  ({status_word, meas_voltage, current_mag, power_mag}),
    .cyc_valid (cyc_valid),
    .cyc_data  (cyc_data),
    .cyc_last  (cyc_last)
  );

  // ==========================================================
  // Byte position within a frame, for the checks only
  always_ff @(posedge core_clk) begin
    if (rst || cyc_last) begin
      cyc_idx <= 5'd0;
    end else if (cyc_valid) begin
      cyc_idx <= cyc_idx + 5'd1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  slot_tail_zero_a: assert property (
    cyc_valid && (cyc_idx >= `CYC_USED_BYTES) |-> cyc_data == 8'h00)
    else $error("unused slot byte not zero");
  frame_length_a: assert property (
    cyc_valid |-> (cyc_last == (cyc_idx == `CYC_FRAME_LAST)))
    else $error("cyclic frame length wrong");
  status_bits_a: assert property (
    req_valid && !req_write
      && req_index == (`OBJ_INDEX_OFFSET + `REG_STATUS_WORD)
    |=> resp_data[`STAT_BIT_MASTER] == $past(is_master)
      && resp_data[`STAT_BIT_OUTPUT_ON] == $past(output_on)
      && resp_data[`STAT_BIT_CC] == $past(constant_current_regulation))
    else $error("status bits 6 7 10 wrong");
  sink_bit_a: assert property (
    req_valid && !req_write
      && req_index == (`OBJ_INDEX_OFFSET + `REG_STATUS_WORD)
    |=> resp_data[`STAT_BIT_SINK] == $past(sink_mode))
    else $error("sink bit wrong");
  current_unsigned_a: assert property (
    req_valid && !req_write && meas_current[16]
      && meas_current != 17'h10000
      && req_index == (`OBJ_INDEX_OFFSET + `REG_MEAS_CURRENT)
    |=> resp_data == {16'h0000, $past(~meas_current[15:0]) + 16'h0001})
    else $error("current not a magnitude");
  range_abort_a: assert property (
    req_valid && req_write && remote_active && req_data[15:0] > `PERCENT_FULL
      && req_index == (`OBJ_INDEX_OFFSET + `REG_SET_VOLTAGE)
    |=> resp_valid && !resp_ok && resp_abort == `ABORT_RANGE
      && $stable(set_voltage))
    else $error("range write not refused");
  locked_write_a: assert property (
    req_valid && req_write && !remote_active
      && req_index == (`OBJ_INDEX_OFFSET + `REG_SET_CURRENT)
    |=> !resp_ok && resp_abort == `ABORT_STATE && $stable(set_current))
    else $error("write without remote accepted");
  read_anytime_a: assert property (
    req_valid && !req_write
      && req_index == (`OBJ_INDEX_OFFSET + `REG_MEAS_VOLTAGE)
    |=> resp_ok && resp_data[15:0] == $past(meas_voltage))
    else $error("read refused");
  nominal_float_a: assert property (
    req_valid && !req_write
      && req_index == (`OBJ_INDEX_OFFSET + `REG_NOMINAL_VOLTAGE)
    |=> resp_ok && resp_data == nominal_voltage_float)
    else $error("nominal voltage read wrong");
  remote_grant_a: assert property (
    req_valid && req_write && remote_permit
      && req_index == (`OBJ_INDEX_OFFSET + `REG_REMOTE_REQUEST)
      && req_data == {16'h0000, `REMOTE_ON_CODE}
    |=> remote_active ##1 remote_active || $past(req_valid))
    else $error("remote request not granted");
  eff_step_a: assert property (
    req_valid && req_write && remote_active
      && req_data <= {16'h0000, `PERCENT_FULL}
      && req_index == (`OBJ_INDEX_OFFSET + `REG_SET_POWER)
    |=> resp_ok && set_power_eff == $past(req_data[15:1]))
    else $error("effective step wrong");

  grant_c: cover property (!remote_active ##1 remote_active);
  frame_c: cover property (cyc_valid && cyc_last);
  range_c: cover property (resp_valid && resp_abort == `ABORT_RANGE);
  setv_c:  cover property (resp_ok && $changed(set_voltage));

endmodule
`default_nettype wire

// ==== testbench/fieldbus_master_model.sv ====
/*
  Behavioural fieldbus master: issues one object access at a time.
  Assumes the mapper answers one cycle after the request is taken.
*/
`timescale 1ns/1ns
`default_nettype none

module fieldbus_master_model (
  input  wire logic         core_clk,
  input  wire logic         resp_valid,
  input  wire logic         resp_ok,
  input  wire logic [31:0]  resp_data,
  input  wire logic [31:0]  resp_abort,
  output logic              req_valid,
  output logic              req_write,
  output logic [15:0]       req_index,
  output logic [31:0]       req_data
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_index = 16'h0000;
    req_data  = 32'h0000_0000;
  end

  // ==========================================================
  // One access; the caller orders the remote request first
  // Percent set values are sent as 0x0000..0xCCCC codes
  task automatic access(input logic wr, input logic [15:0] idx,
                        input logic [31:0] d, output logic v,
                        output logic ok, output logic [31:0] data,
                        output logic [31:0] abrt);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_index = idx;
    req_data  = d;
    @(negedge core_clk);
    v    = resp_valid;
    ok   = resp_ok;
    data = resp_data;
    abrt = resp_abort;
    // Released lines show junk so a stale value is never trusted
    req_valid = 1'b0;
    req_write = ~wr;
    req_index = ~idx;
    req_data  = ~d;
  endtask
endmodule
`default_nettype wire

// ==== testbench/fieldbus_object_mapper_test.sv ====
/*
  Self-checking bench for the fieldbus object mapper.
  Assumes the design files and the master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_object_mapper_defs.svh"

module fieldbus_object_mapper_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid, req_write, resp_valid, resp_ok;
  logic [15:0] req_index;
  logic [31:0] req_data, resp_data, resp_abort;
  logic        remote_permit = 1'b0;
  logic        is_master = 1'b0;
  logic        output_on = 1'b0;
  logic        ccr = 1'b0;
  logic        sink_mode = 1'b0;
  logic [31:0] status_other = 32'h0000_0000;
  logic [15:0] meas_voltage = 16'h0000;
  logic [16:0] meas_current = 17'h00000;
  logic [16:0] meas_power = 17'h00000;
  logic        cyc_req = 1'b0;
  logic        remote_active, cyc_valid, cyc_last;
  logic [14:0] set_v, set_c, set_p;
  logic [7:0]  cyc_data;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  fieldbus_object_mapper uut (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_data(req_data),
    .remote_permit(remote_permit), .is_master(is_master),
    .output_on(output_on), .constant_current_regulation(ccr),
    .sink_mode(sink_mode), .status_other(status_other),
    .meas_voltage(meas_voltage), .meas_current(meas_current),
    .meas_power(meas_power), .cyc_req(cyc_req),
    .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_data(resp_data),
    .resp_abort(resp_abort), .remote_active(remote_active),
    .set_voltage_eff(set_v), .set_current_eff(set_c),
    .set_power_eff(set_p), .cyc_valid(cyc_valid), .cyc_data(cyc_data),
    .cyc_last(cyc_last));

  fieldbus_master_model master (
    .core_clk(core_clk), .resp_valid(resp_valid), .resp_ok(resp_ok),
    .resp_data(resp_data), .resp_abort(resp_abort),
    .req_valid(req_valid), .req_write(req_write),
    .req_index(req_index), .req_data(req_data));

  // ==========================================================
  // Clock, and a ceiling well above the hundred or so cycles used
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Comparison, verdict and one checked access
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic req(input logic wr, input logic [15:0] idx,
                     input logic [31:0] d, input logic [31:0] abrt,
                     input logic [31:0] exp_data);
    logic v, ok;
    logic [31:0] data, ab;
    master.access(wr, idx, d, v, ok, data, ab);
    check("resp_valid", {31'd0, v}, 32'd1);
    check("resp_ok", {31'd0, ok}, {31'd0, abrt == `ABORT_NONE});
    check("resp_abort", ab, abrt);
    check("resp_data", data, exp_data);
  endtask

  // ==========================================================
  // Reads need no remote control; status bits follow live inputs
  task automatic test_reads();
    is_master = 1'b1;
    output_on = 1'b1;
    ccr = 1'b1;
    meas_voltage = 16'h263A;
    req(1'b0, 16'h21FA, 32'h0, `ABORT_NONE, 32'h0000_04C0);
    sink_mode = 1'b1;
    req(1'b0, 16'h21FA, 32'h0, `ABORT_NONE, 32'h0000_14C0);
    req(1'b0, 16'h207A, 32'h0, `ABORT_NONE, 32'h4348_0000);
    req(1'b0, 16'h21FC, 32'h0, `ABORT_NONE, 32'h0000_263A);
  endtask

  // Remote grant: refused without permit or with a bad code
  task automatic test_remote();
    req(1'b1, 16'h21F5, 32'h1000, `ABORT_STATE, 32'h0);
    req(1'b1, 16'h2193, 32'hFF00, `ABORT_STATE, 32'h0);
    remote_permit = 1'b1;
    req(1'b1, 16'h2193, 32'h1234, `ABORT_RANGE, 32'h0);
    req(1'b1, 16'h2193, 32'hFF00, `ABORT_NONE, 32'h0);
    check("remote_active", {31'd0, remote_active}, 32'd1);
    req(1'b0, 16'h2193, 32'h0, `ABORT_NONE, 32'h0000_FF00);
  endtask

  // Set values at the range edges, then release of remote control
  task automatic test_setvals();
    req(1'b1, 16'h21F5, 32'hCCCC, `ABORT_NONE, 32'h0);
    check("set_v", {17'd0, set_v}, 32'd26214);
    req(1'b1, 16'h21F5, 32'hCCCD, `ABORT_RANGE, 32'h0);
    check("set_v", {17'd0, set_v}, 32'd26214);
    req(1'b0, 16'h21F5, 32'h0, `ABORT_NONE, 32'h0000_CCCC);
    req(1'b1, 16'h21F6, 32'hCCCD, `ABORT_RANGE, 32'h0);
    check("set_c", {17'd0, set_c}, 32'd0);
    req(1'b1, 16'h21F7, 32'h0003, `ABORT_NONE, 32'h0);
    check("set_p", {17'd0, set_p}, 32'd1);
    req(1'b1, 16'h21FA, 32'h0, `ABORT_READ_ONLY, 32'h0);
    req(1'b0, 16'h2000, 32'h0, `ABORT_NO_OBJECT, 32'h0);
    req(1'b1, 16'h2193, 32'h0000, `ABORT_NONE, 32'h0);
    check("remote_active", {31'd0, remote_active}, 32'd0);
    req(1'b1, 16'h21F6, 32'h0100, `ABORT_STATE, 32'h0);
  endtask

  // One cyclic frame; current and power given as signed readings
  task automatic test_cyclic(input logic [15:0] v, input logic [16:0] c,
                             input logic [16:0] p, input logic [15:0] cm,
                             input logic [15:0] pm);
    logic [143:0] exp;
    int i;
    meas_voltage = v;
    meas_current = c;
    meas_power = p;
    exp = {19'd0, sink_mode, 1'b0, ccr, 2'b00, output_on, is_master,
           6'd0, v, cm, pm, 64'd0};
    @(negedge core_clk);
    cyc_req = 1'b1;
    @(negedge core_clk);
    cyc_req = 1'b0;
    for (i = 0; i < 4 && cyc_valid !== 1'b1; i++)
      @(negedge core_clk);
    for (i = 0; i < 18; i++) begin
      check("cyc_valid", {31'd0, cyc_valid}, 32'd1);
      check("cyc_last", {31'd0, cyc_last}, {31'd0, i == 17});
      check("cyc_data", {24'd0, cyc_data}, {24'd0, exp[143-8*i -: 8]});
      @(negedge core_clk);
    end
    check("cyc_valid", {31'd0, cyc_valid}, 32'd0);
    req(1'b0, 16'h21FD, 32'h0, `ABORT_NONE, {16'h0000, cm});
    req(1'b0, 16'h21FE, 32'h0, `ABORT_NONE, {16'h0000, pm});
  endtask

  // ==========================================================
  // Main sequence: reset for eight cycles, then the scenarios
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    test_reads();
    test_remote();
    test_setvals();
    test_cyclic(16'h263A, 17'h1F365, 17'h00925, 16'h0C9B, 16'h0925);
    sink_mode = 1'b0;
    ccr = 1'b0;
    test_cyclic(16'h1111, 17'h00222, 17'h10000, 16'h0222, 16'hFFFF);
    end_of_test();
  end
endmodule
`default_nettype wire
